// >>> design/seq_exit_pkg.sv
// Function
// - Sequence exit when selected input reaches expected level, then go to next state
// - Sequence delay timer programmable from 10 us to 400 ms
// - Monitor exit is OR of deviating monitored inputs, no delay
// - After any exit, load next definition from storage, about 20 us
// - Timeout exit to timeout next state when condition unmet at expiry
// - Timeout delay programmable per state, 100 us to 400 ms
// - Driver output levels of a state applied on entry
// - Sequence condition may use supply above undervoltage threshold
// - One sticky fault bit per input, held in two registers
// - Fault bits readable by host software
// - Per-state enable decides whether faults are recorded
// - Up to 63 states, any reachable, each fixing ten driver outputs
// - OR of all warnings is an input to all three exit blocks
// - Jump command forces advance to the sequence next state via the sequence exit
// - First definition loaded 0.5 ms after configuration download
package seq_exit_pkg;
  localparam int CLK_MHZ = 40;
  localparam int N_IN = 10;
  localparam int N_OUT = 10;
  localparam int SEL_W = 4;
  localparam int ST_W = 6;
  localparam int N_STATES = 63;
  localparam int TMR_W = 24;
  localparam int DEF_W = 64;
  // Timer counts in 10 us units: 1 .. 40000
  localparam int TICK_US = 10;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int SEQ_MIN_US = 10;
  localparam int TMO_MIN_US = 100;
  localparam int MAX_MS = 400;
  localparam int SEQ_MIN_TICKS = SEQ_MIN_US / TICK_US;
  localparam int TMO_MIN_TICKS = TMO_MIN_US / TICK_US;
  localparam int MAX_TICKS = MAX_MS * 1000 / TICK_US;
  localparam int LOAD_US = 20;
  localparam int LOAD_CYC = LOAD_US * CLK_MHZ;
  localparam int START_US = 500;
  localparam int START_CYC = START_US * CLK_MHZ;
  localparam int TICK_CW = 9;
  localparam int LOAD_CW = 10;
  localparam int START_CW = 15;
  // Field layout of a 64-bit state definition
  localparam int F_OUT_LSB = 0;
  localparam int F_SEQ_NEXT_LSB = 10;
  localparam int F_TMO_NEXT_LSB = 16;
  localparam int F_MON_NEXT_LSB = 22;
  localparam int F_SEQ_SEL_LSB = 28;
  localparam int F_SEQ_POL = 32;
  localparam int F_SEQ_WARN = 33;
  localparam int F_TMO_EN = 34;
  localparam int F_FLT_EN = 35;
  localparam int F_MON_WARN = 36;
  localparam int F_TMO_WARN = 37;
  localparam int F_SEQ_DLY_LSB = 38;
  localparam int F_TMO_DLY_LSB = 48;
  localparam int DLY_W = 10;
  localparam int F_MON_MASK_LSB = 40;
  localparam logic [ST_W-1:0] FIRST_STATE = 6'h00;
  typedef enum logic [1:0] {exit_none_t_v, exit_mon, exit_seq, exit_tmo} exit_kind_t;
endpackage : seq_exit_pkg

// >>> design/exit_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for a bus of levels
module exit_sync
  import seq_exit_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = d;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q = sync_ff;
endmodule : exit_sync
`default_nettype wire

// >>> design/exit_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Delay timer counting ticks; restarts on clear
module exit_timer
  import seq_exit_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  input wire logic [TMR_W-1:0] limit,
  output logic expired
);
  logic [TMR_W-1:0] cnt_ff;
  logic [TMR_W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (clear) begin
      nxt_cnt = '0;
    end else if (tick && (cnt_ff < limit)) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign expired = !clear && (cnt_ff >= limit);
endmodule : exit_timer
`default_nettype wire

// >>> design/sequencing_engine_exit.sv
`timescale 1ns/100ps
`default_nettype none
module sequencing_engine_exit
  import seq_exit_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic config_done,
  input wire logic [N_IN-1:0] supply_fault_detector,
  input wire logic warning_in,
  input wire logic jump_cmd,
  input wire logic fault_clear,
  input wire logic [DEF_W-1:0] def_data,
  input wire logic def_valid,
  output logic [ST_W-1:0] def_addr,
  output logic def_req,
  output logic [ST_W-1:0] cur_state,
  output logic [N_OUT-1:0] programmable_driver_output,
  output logic [7:0] fault_lo,
  output logic [7:0] fault_hi,
  output logic running
);
  typedef enum logic [1:0] {wait_cfg, loading, active} phase_t;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [N_IN-1:0] sfd_s;
  logic warn_s;
  logic cfg_s;
  logic jump_s;
  logic [N_IN+2:0] sync_d;
  logic [N_IN+2:0] sync_q;

  assign sync_d = {jump_cmd, cfg_s_in(config_done), warning_in, supply_fault_detector};
  assign sfd_s = sync_q[N_IN-1:0];
  assign warn_s = sync_q[N_IN];
  assign cfg_s = sync_q[N_IN+1];
  assign jump_s = sync_q[N_IN+2];

  function automatic logic cfg_s_in(input logic v);
    return v;
  endfunction : cfg_s_in

  exit_sync #(.W(N_IN + 3)) u_sync (
    .clock(clock),
    .rst(rst),
    .d(sync_d),
    .q(sync_q)
  );

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  function automatic logic [TMR_W-1:0] clamp_dly(input logic [DLY_W-1:0] raw,
                                                 input int lo);
    logic [TMR_W-1:0] v;
    v = TMR_W'(raw) * TMR_W'(MAX_TICKS / 1000);
    if (v < TMR_W'(lo)) begin
      v = TMR_W'(lo);
    end
    if (v > TMR_W'(MAX_TICKS)) begin
      v = TMR_W'(MAX_TICKS);
    end
    return v;
  endfunction : clamp_dly

  function automatic logic [ST_W-1:0] next_field(input logic [DEF_W-1:0] d,
                                                 input int lsb);
    return d[lsb +: ST_W];
  endfunction : next_field

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  phase_t phase_ff, nxt_phase;
  logic [DEF_W-1:0] def_ff, nxt_def;
  logic [ST_W-1:0] state_ff, nxt_state;
  logic [ST_W-1:0] addr_ff, nxt_addr;
  logic req_ff, nxt_req;
  logic [N_OUT-1:0] out_ff, nxt_out;
  logic [N_IN-1:0] fault_ff;
  logic [START_CW-1:0] start_ff, nxt_start;
  logic [LOAD_CW-1:0] load_ff, nxt_load;
  logic [TICK_CW-1:0] tick_ff, nxt_tick;
  logic run_ff, nxt_run;
  logic entry_ff, nxt_entry;
  logic jump_d_ff, nxt_jump_d;

  logic tick;
  logic seq_done;
  logic tmo_done;
  logic seq_cond;
  logic mon_hit;
  logic jump_pulse;
  logic [SEL_W-1:0] sel;
  logic sel_bit;
  logic [N_IN-1:0] mon_mask;
  logic [N_IN-1:0] mon_dev;
  exit_kind_t exit_kind;

  assign tick = (tick_ff == TICK_CW'(TICK_CYC - 1));
  assign jump_pulse = jump_s && !jump_d_ff;
  assign sel = def_ff[F_SEQ_SEL_LSB +: SEL_W];
  assign sel_bit = (sel < SEL_W'(N_IN)) ? sfd_s[sel] : 1'b0;
  assign mon_mask = def_ff[F_MON_MASK_LSB - 30 +: N_IN];

  // Monitored inputs expected high; a low one deviates
  assign mon_dev = mon_mask & ~sfd_s;
  assign mon_hit = (|mon_dev) || (def_ff[F_MON_WARN] && warn_s);
  assign seq_cond = (sel_bit == def_ff[F_SEQ_POL]) ||
                    (def_ff[F_SEQ_WARN] && warn_s);

  exit_timer u_seq_tmr (
    .clock(clock),
    .rst(rst),
    .clear(entry_ff),
    .tick(tick),
    .limit(clamp_dly(def_ff[F_SEQ_DLY_LSB +: DLY_W], SEQ_MIN_TICKS)),
    .expired(seq_done)
  );

  exit_timer u_tmo_tmr (
    .clock(clock),
    .rst(rst),
    .clear(entry_ff),
    .tick(tick),
    .limit(clamp_dly(def_ff[F_TMO_DLY_LSB +: DLY_W], TMO_MIN_TICKS)),
    .expired(tmo_done)
  );

  // ---------------------------------------------------------------
  // Fault latch, one sticky bit per input
  // ---------------------------------------------------------------
  logic flt_rec;

  // Recording only while a state with its enable bit is active
  assign flt_rec = (phase_ff == active) && def_ff[F_FLT_EN];

  for (genvar i = 0; i < N_IN; i++) begin : g_fault
    logic bit_ff;
    logic nxt_bit;

    // Set wins over clear
    always_comb begin
      nxt_bit = bit_ff;
      if (fault_clear) begin
        nxt_bit = 1'b0;
      end
      if (flt_rec && mon_dev[i]) begin
        nxt_bit = 1'b1;
      end
    end

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        bit_ff <= 1'b0;
      end else begin
        bit_ff <= nxt_bit;
      end
    end

    assign fault_ff[i] = bit_ff;
  end

  // ---------------------------------------------------------------
  // Exit arbitration
  // ---------------------------------------------------------------
  always_comb begin
    exit_kind = exit_none_t_v;
    if (phase_ff == active && !entry_ff) begin
      if (mon_hit) begin
        exit_kind = exit_mon;
      end else if ((seq_cond && seq_done) || jump_pulse) begin
        exit_kind = exit_seq;
      end else if (def_ff[F_TMO_EN] &&
                   (tmo_done || (def_ff[F_TMO_WARN] && warn_s))) begin
        exit_kind = exit_tmo;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_phase = phase_ff;
    nxt_def = def_ff;
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_req = 1'b0;
    nxt_out = out_ff;
    nxt_start = start_ff;
    nxt_load = load_ff;
    nxt_tick = tick ? '0 : tick_ff + 1'b1;
    nxt_run = run_ff;
    nxt_entry = 1'b0;
    nxt_jump_d = jump_s;
    unique case (phase_ff)
      wait_cfg: begin
        if (!cfg_s) begin
          nxt_start = '0;
        end else if (start_ff == START_CW'(START_CYC - 1)) begin
          nxt_phase = loading;
          nxt_addr = FIRST_STATE;
          nxt_req = 1'b1;
          nxt_load = '0;
        end else begin
          nxt_start = start_ff + 1'b1;
        end
      end
      loading: begin
        if (load_ff != LOAD_CW'(LOAD_CYC - 1)) begin
          nxt_load = load_ff + 1'b1;
        end
        // Definition accepted after the fixed load latency
        if (def_valid && load_ff == LOAD_CW'(LOAD_CYC - 1)) begin
          nxt_def = def_data;
          nxt_state = addr_ff;
          nxt_out = def_data[F_OUT_LSB +: N_OUT];
          nxt_phase = active;
          nxt_entry = 1'b1;
          nxt_run = 1'b1;
        end
      end
      active: begin
        if (exit_kind != exit_none_t_v) begin
          nxt_phase = loading;
          nxt_req = 1'b1;
          nxt_load = '0;
          unique case (exit_kind)
            exit_mon: nxt_addr = next_field(def_ff, F_MON_NEXT_LSB);
            exit_seq: nxt_addr = next_field(def_ff, F_SEQ_NEXT_LSB);
            exit_tmo: nxt_addr = next_field(def_ff, F_TMO_NEXT_LSB);
            default: nxt_addr = addr_ff;
          endcase
          if (nxt_addr >= ST_W'(N_STATES)) begin
            nxt_addr = FIRST_STATE;
          end
        end
      end
      default: nxt_phase = wait_cfg;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_ff <= wait_cfg;
      def_ff <= '0;
      state_ff <= FIRST_STATE;
      addr_ff <= FIRST_STATE;
      req_ff <= 1'b0;
      out_ff <= '0;
      start_ff <= '0;
      load_ff <= '0;
      tick_ff <= '0;
      run_ff <= 1'b0;
      entry_ff <= 1'b0;
      jump_d_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      def_ff <= nxt_def;
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      req_ff <= nxt_req;
      out_ff <= nxt_out;
      start_ff <= nxt_start;
      load_ff <= nxt_load;
      tick_ff <= nxt_tick;
      run_ff <= nxt_run;
      entry_ff <= nxt_entry;
      jump_d_ff <= nxt_jump_d;
    end
  end

  // Fault bits split over two byte registers
  assign fault_lo = fault_ff[7:0];
  assign fault_hi = {6'h00, fault_ff[N_IN-1:8]};
  assign def_addr = addr_ff;
  assign def_req = req_ff;
  assign cur_state = state_ff;
  assign programmable_driver_output = out_ff;
  assign running = run_ff;
endmodule : sequencing_engine_exit
`default_nettype wire

// >>> verification/seq_exit_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module seq_exit_checker
  import seq_exit_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic config_done,
  input wire logic fault_clear,
  input wire logic [ST_W-1:0] def_addr,
  input wire logic def_req,
  input wire logic [ST_W-1:0] cur_state,
  input wire logic [N_OUT-1:0] programmable_driver_output,
  input wire logic [7:0] fault_lo,
  input wire logic [7:0] fault_hi,
  input wire logic running
);
  // ----------------
  // Cycle counters
  // ----------------
  logic [9:0] ld_ff, nxt_ld;
  logic [14:0] cd_ff, nxt_cd;
  always_comb begin
    nxt_ld = def_req ? 10'h000 : ld_ff + 10'(ld_ff != 10'h3ff);
    nxt_cd = config_done ? cd_ff + 15'(cd_ff != 15'h7fff) : 15'h0000;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ld_ff <= 10'h000;
      cd_ff <= 15'h0000;
    end else begin
      ld_ff <= nxt_ld;
      cd_ff <= nxt_cd;
    end
  end
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_req_one_cycle: assert property (def_req |=> !def_req)
    else $error("def_req longer than one cycle");
  a_load_wait: assert property ($changed(cur_state) |-> ld_ff >= LOAD_CYC - 2)
    else $error("state entered before load time");
  a_state_from_addr: assert property ($changed(cur_state) |-> cur_state == def_addr)
    else $error("state differs from requested address");
  a_addr_with_req: assert property ($changed(def_addr) |-> def_req)
    else $error("address moved without request");
  a_out_on_entry: assert property ($changed(programmable_driver_output) |->
    running && ld_ff >= LOAD_CYC - 2)
    else $error("driver outputs changed outside entry");
  a_fault_stays_set: assert property (!$past(fault_clear) |->
    (fault_lo & $past(fault_lo)) == $past(fault_lo) && (fault_hi & $past(fault_hi)) == $past(fault_hi))
    else $error("fault bit fell without clear");
  a_fault_hi_width: assert property (fault_hi[7:2] == 6'h00)
    else $error("fault_hi unused bits set");
  a_start_wait: assert property ($rose(def_req) && !running |-> cd_ff >= START_CYC)
    else $error("first request too early");
  a_first_addr: assert property (def_req && !running |-> def_addr == FIRST_STATE)
    else $error("first request not state zero");
  a_run_holds: assert property (running |=> running)
    else $error("running fell");
  c_entry: cover property ($changed(cur_state));
  c_reload: cover property (def_req && running);
  c_fault: cover property ($rose(fault_lo != 8'h00));
endmodule : seq_exit_checker
bind sequencing_engine_exit seq_exit_checker u_chk (.clock(clock), .rst(rst),
  .config_done(config_done), .fault_clear(fault_clear), .def_addr(def_addr),
  .def_req(def_req), .cur_state(cur_state),
  .programmable_driver_output(programmable_driver_output),
  .fault_lo(fault_lo), .fault_hi(fault_hi), .running(running));
`default_nettype wire

// >>> verification/def_store_model.sv
`timescale 1ns/100ps
`default_nettype none
module def_store_model
  import seq_exit_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic def_req,
  input wire logic [ST_W-1:0] def_addr,
  output logic [DEF_W-1:0] def_data,
  output logic def_valid
);
  logic [DEF_W-1:0] mem [64];
  logic [ST_W-1:0] addr_ff;
  int lat = 50;
  int wait_ff;
  // ----------------
  // Answer after lat cycles, toggling while invalid
  // ----------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      def_valid <= 1'b0;
      def_data <= '0;
      addr_ff <= '0;
      wait_ff <= 0;
    end else if (def_req) begin
      addr_ff <= def_addr;
      wait_ff <= 0;
      def_valid <= 1'b0;
      def_data <= ~def_data;
    end else if (!def_valid) begin
      wait_ff <= wait_ff + 1;
      def_data <= (wait_ff >= lat) ? mem[addr_ff] : ~def_data;
      def_valid <= (wait_ff >= lat);
    end
  end
endmodule : def_store_model
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import seq_exit_pkg::*; ;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic config_done = 1'b0;
  logic [N_IN-1:0] supply_ok = 10'h3fe;
  logic warning_in = 1'b0;
  logic jump_cmd = 1'b0;
  logic fault_clear = 1'b0;
  logic [DEF_W-1:0] def_data;
  logic def_valid, def_req, running;
  logic [ST_W-1:0] def_addr, cur_state;
  logic [N_OUT-1:0] drv_out;
  logic [7:0] fault_lo, fault_hi;
  int errors = 0;
  int tests_run = 0;
  always #12.5 clock = ~clock;
  sequencing_engine_exit u_dut (.clock(clock), .rst(rst), .config_done(config_done),
    .supply_fault_detector(supply_ok), .warning_in(warning_in), .jump_cmd(jump_cmd),
    .fault_clear(fault_clear), .def_data(def_data), .def_valid(def_valid),
    .def_addr(def_addr), .def_req(def_req), .cur_state(cur_state),
    .programmable_driver_output(drv_out), .fault_lo(fault_lo), .fault_hi(fault_hi),
    .running(running));
  def_store_model u_store (.clock(clock), .rst(rst), .def_req(def_req),
    .def_addr(def_addr), .def_data(def_data), .def_valid(def_valid));
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [63:0] mk(logic [9:0] o, logic [5:0] sn, tn, mn, logic [3:0] sel,
    logic pol, mw, fe, te, logic [9:0] sd, td);
    return {6'h00, td, sd, 1'b0, mw, fe, te, 1'b0, pol, sel, mn, tn, sn, o};
  endfunction : mk
  task automatic chk(input string name, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wait_st(input logic [ST_W-1:0] s, input int lim);
    int n;
    n = 0;
    while (cur_state !== s && n < lim) begin
      @(negedge clock);
      n++;
    end
    chk("cur_state", 16'(s), 16'(cur_state));
  endtask : wait_st
  task automatic stay(input logic [ST_W-1:0] s, input int n);
    repeat (n) @(negedge clock);
    chk("cur_state", 16'(s), 16'(cur_state));
  endtask : stay
  task automatic summarize;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (80000) @(posedge clock);
    errors++;
    summarize();
  end
  // ----------------
  // Sequence
  // ----------------
  initial begin
    for (int i = 0; i < 64; i++) u_store.mem[i] = '0;
    u_store.mem[0] = mk(10'h001, 6'h02, 6'h00, 6'h05, 4'h0, 1, 0, 1, 0, 10'h000, 10'h000);
    u_store.mem[5] = mk(10'h3ff, 6'h03, 6'h07, 6'h00, 4'h2, 1, 0, 0, 1, 10'h001, 10'h002);
    u_store.mem[3] = mk(10'h155, 6'h04, 6'h09, 6'h00, 4'h3, 0, 0, 0, 1, 10'h000, 10'h000);
    u_store.mem[9] = mk(10'h2aa, 6'h0c, 6'h00, 6'h00, 4'h4, 0, 0, 0, 0, 10'h000, 10'h000);
    u_store.mem[12] = mk(10'h0f0, 6'h00, 6'h00, 6'h14, 4'h4, 0, 1, 1, 0, 10'h000, 10'h000);
    u_store.mem[20] = mk(10'h000, 6'h01, 6'h00, 6'h14, 4'h0, 0, 0, 0, 0, 10'h000, 10'h000);
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    config_done <= 1'b1;
    repeat (19000) @(negedge clock);
    chk("running", 16'h0000, 16'(running));
    for (int n = 0; n < 3000 && running !== 1'b1; n++) @(negedge clock);
    chk("running", 16'h0001, 16'(running));
    chk("drv_out", 16'h0001, 16'(drv_out));
    stay(6'h00, 1000);
    @(posedge clock);
    supply_ok <= 10'h3fd;
    repeat (100) @(posedge clock);
    supply_ok <= 10'h3ff;
    wait_st(6'h05, 1500);
    chk("drv_out", 16'h03ff, 16'(drv_out));
    chk("fault_lo", 16'h0002, 16'(fault_lo));
    stay(6'h05, 15000);
    wait_st(6'h03, 2500);
    chk("drv_out", 16'h0155, 16'(drv_out));
    u_store.lat = 1200;
    stay(6'h03, 3700);
    wait_st(6'h09, 2500);
    u_store.lat = 50;
    chk("drv_out", 16'h02aa, 16'(drv_out));
    stay(6'h09, 600);
    @(posedge clock);
    jump_cmd <= 1'b1;
    repeat (5) @(posedge clock);
    jump_cmd <= 1'b0;
    wait_st(6'h0c, 1200);
    stay(6'h0c, 600);
    @(posedge clock);
    warning_in <= 1'b1;
    wait_st(6'h14, 1200);
    @(posedge clock);
    warning_in <= 1'b0;
    supply_ok <= 10'h3fe;
    repeat (200) @(negedge clock);
    chk("fault_lo", 16'h0002, 16'(fault_lo));
    @(posedge clock);
    supply_ok <= 10'h3ff;
    fault_clear <= 1'b1;
    @(posedge clock);
    fault_clear <= 1'b0;
    repeat (2) @(negedge clock);
    chk("fault_lo", 16'h0000, 16'(fault_lo));
    chk("fault_hi", 16'h0000, 16'(fault_hi));
    summarize();
  end
endmodule : tb
`default_nettype wire
